// file: shared/sep_pkg.sv
// package for the serial echo and output point block
// assumes a 125 MHz pclk and an apb slave with 12-bit byte addresses
package sep_pkg;

  // clock and line rate
  localparam int CLK_HZ    = 125_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int DATA_BITS = 8;

  // apb register byte offsets
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] OFS_POINT  = 12'h000; // write-only output points
  localparam logic [11:0] OFS_STATUS = 12'h004; // read-only block state
  localparam logic [11:0] OFS_RXDATA = 12'h008; // read pops one character
  localparam logic [11:0] OFS_TXDATA = 12'h00c; // write sends one character

  // point write field layout
  localparam int PT_LSB  = 0;
  localparam int PT_W    = 7;
  localparam int VAL_BIT = 8;

  // output point numbering
  localparam logic [6:0] PT_FIRST  = 7'h11; // point 17 is unit 1 output 1
  localparam logic [6:0] PT_LAST   = 7'h60; // point 96 is unit 10 output 8
  localparam int         UNITS     = 10;
  localparam int         OUTS_UNIT = 8;
  localparam int         NOUT      = UNITS * OUTS_UNIT;

  // character and status fields
  localparam int CH_BIT      = 8;  // channel select in txdata, channel tag in rxdata
  localparam int RXV_BIT     = 31; // rxdata holds a character
  localparam int ST_LB       = 0;
  localparam int ST_RXV      = 1;
  localparam int ST_TXB0     = 2;
  localparam int ST_FULL     = 4;

  // loopback switch pattern: bank 2 way 5 on, all others off
  localparam logic [7:0] LB_PATTERN = 8'h10;

  // shared one-hot state codes for receiver and transmitter
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_START = 4'h2,
    S_DATA  = 4'h4,
    S_STOP  = 4'h8
  } sep_st_t;

  typedef struct packed {
    sep_st_t     rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        hold_v;
    logic [7:0]  hold_d;
    sep_st_t     tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        txd;
    logic        de;
  } sep_ch_t;

  typedef struct packed {
    logic [NOUT-1:0] dout;
    logic            lb;
    sep_ch_t [1:0]   ch;
    logic [1:0][8:0] fq;
    logic            fwr;
    logic            frd;
    logic [1:0]      fcnt;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } sep_state_t;

endpackage

// file: hdl/sep_top.sv
// serial echo, character port and remote digital output points
// assumes synchronous inputs, apb master on pclk, idle-high serial lines
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns

module sep_top #(
  parameter int BIT_CYC = sep_pkg::CLK_HZ / sep_pkg::BAUD_RATE
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [sep_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [7:0]                dip_bank2,
  input  wire logic                      pc_rxd,
  output logic                           pc_txd,
  input  wire logic                      net_rxd,
  output logic                           net_txd,
  output logic                           net_de,
  output logic [sep_pkg::NOUT-1:0]       dout
);

  localparam logic [15:0] BIT_M1  = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_M1 = 16'(BIT_CYC / 2 - 1);

  sep_pkg::sep_state_t s_r;
  sep_pkg::sep_state_t s_nxt;
  logic [1:0]          rxd;
  logic                acc;
  logic                done;
  logic                txw;

  // point number decoding
  function automatic logic pt_ok(input logic [31:0] d);
    logic [6:0] p;
    p = d[sep_pkg::PT_LSB +: sep_pkg::PT_W];
    return (p >= sep_pkg::PT_FIRST) && (p <= sep_pkg::PT_LAST);
  endfunction

  function automatic logic [6:0] pt_idx(input logic [31:0] d);
    return d[sep_pkg::PT_LSB +: sep_pkg::PT_W] - sep_pkg::PT_FIRST;
  endfunction

  assign rxd  = {net_rxd, pc_rxd};
  assign acc  = psel & penable;
  assign done = acc & s_r.pready;
  assign txw  = done & pwrite & (paddr == sep_pkg::OFS_TXDATA) & ~s_r.lb;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_nxt    = s_r;
    s_nxt.lb = (dip_bank2 == sep_pkg::LB_PATTERN);
    // apb: one wait state, answer prepared before pready rises
    s_nxt.pready = acc & ~s_r.pready;
    if (acc && !s_r.pready) begin
      s_nxt.prdata  = '0; // point and txdata registers read zero
      s_nxt.pslverr = 1'b0;
      case (paddr)
        sep_pkg::OFS_POINT, sep_pkg::OFS_TXDATA: begin
        end
        sep_pkg::OFS_STATUS: begin
          s_nxt.prdata[sep_pkg::ST_LB]      = s_r.lb;
          s_nxt.prdata[sep_pkg::ST_RXV]     = (s_r.fcnt != 2'h0);
          s_nxt.prdata[sep_pkg::ST_TXB0]    = s_r.ch[0].tx_st != sep_pkg::S_IDLE;
          s_nxt.prdata[sep_pkg::ST_TXB0+1]  = s_r.ch[1].tx_st != sep_pkg::S_IDLE;
          s_nxt.prdata[sep_pkg::ST_FULL]    = (s_r.fcnt == 2'h2);
        end
        sep_pkg::OFS_RXDATA: begin
          s_nxt.prdata[8:0]              = s_r.fq[s_r.frd];
          s_nxt.prdata[sep_pkg::RXV_BIT] = (s_r.fcnt != 2'h0);
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // output point write, offset from point 17
    if (done && pwrite && paddr == sep_pkg::OFS_POINT && pt_ok(pwdata)) begin
      s_nxt.dout[pt_idx(pwdata)] = pwdata[sep_pkg::VAL_BIT];
    end
    // buffer pop by a completed rxdata read
    if (done && !pwrite && paddr == sep_pkg::OFS_RXDATA && s_r.fcnt != 2'h0) begin
      s_nxt.frd  = ~s_r.frd;
      s_nxt.fcnt = s_r.fcnt - 2'h1;
    end
    // buffer push from one held character; a full buffer stalls the hold
    if (!s_r.lb && s_r.fcnt != 2'h2 && (s_r.ch[0].hold_v || s_r.ch[1].hold_v)) begin
      s_nxt.fq[s_r.fwr] = s_r.ch[0].hold_v ? {1'b0, s_r.ch[0].hold_d}
                                          : {1'b1, s_r.ch[1].hold_d};
      s_nxt.fwr         = ~s_r.fwr;
      s_nxt.fcnt        = s_nxt.fcnt + 2'h1;
      if (s_r.ch[0].hold_v) s_nxt.ch[0].hold_v = 1'b0;
      else s_nxt.ch[1].hold_v = 1'b0;
    end
    // both channels alike, receive and transmit run independently
    for (int c = 0; c < 2; c++) begin
      // transmitter
      case (s_r.ch[c].tx_st)
        sep_pkg::S_IDLE: begin
          s_nxt.ch[c].txd = 1'b1;
          s_nxt.ch[c].de  = 1'b0;
          if ((s_r.lb && s_r.ch[c].hold_v) ||
              (txw && pwdata[sep_pkg::CH_BIT] == c[0])) begin
            s_nxt.ch[c].tx_sh  = s_r.lb ? s_r.ch[c].hold_d : pwdata[7:0];
            s_nxt.ch[c].hold_v = s_r.lb ? 1'b0 : s_nxt.ch[c].hold_v;
            s_nxt.ch[c].tx_st  = sep_pkg::S_START;
            s_nxt.ch[c].tx_cnt = BIT_M1;
            s_nxt.ch[c].txd    = 1'b0;
            s_nxt.ch[c].de     = 1'b1;
          end
        end
        sep_pkg::S_START, sep_pkg::S_DATA, sep_pkg::S_STOP: begin
          s_nxt.ch[c].tx_cnt = s_r.ch[c].tx_cnt - 16'h1;
          if (s_r.ch[c].tx_cnt == 16'h0) begin
            s_nxt.ch[c].tx_cnt = BIT_M1;
            if (s_r.ch[c].tx_st == sep_pkg::S_START) begin
              s_nxt.ch[c].tx_st  = sep_pkg::S_DATA;
              s_nxt.ch[c].tx_bit = 3'h0;
              s_nxt.ch[c].txd    = s_r.ch[c].tx_sh[0];
            end else if (s_r.ch[c].tx_st == sep_pkg::S_DATA) begin
              s_nxt.ch[c].tx_sh  = s_r.ch[c].tx_sh >> 1;
              s_nxt.ch[c].tx_bit = s_r.ch[c].tx_bit + 3'h1;
              s_nxt.ch[c].txd    = s_r.ch[c].tx_sh[1];
              if (s_r.ch[c].tx_bit == 3'(sep_pkg::DATA_BITS - 1)) begin
                s_nxt.ch[c].tx_st = sep_pkg::S_STOP; // no parity, one stop
                s_nxt.ch[c].txd   = 1'b1;
              end
            end else begin
              s_nxt.ch[c].tx_st = sep_pkg::S_IDLE;
              s_nxt.ch[c].de    = 1'b0;
            end
          end
        end
        default: s_nxt.ch[c].tx_st = sep_pkg::S_IDLE;
      endcase
      // receiver, sampled mid-bit
      s_nxt.ch[c].rx_cnt = s_r.ch[c].rx_cnt - 16'h1;
      case (s_r.ch[c].rx_st)
        sep_pkg::S_IDLE: begin
          if (!rxd[c]) begin
            s_nxt.ch[c].rx_st  = sep_pkg::S_START;
            s_nxt.ch[c].rx_cnt = HALF_M1;
          end
        end
        sep_pkg::S_START: begin
          if (s_r.ch[c].rx_cnt == 16'h0) begin
            s_nxt.ch[c].rx_st  = rxd[c] ? sep_pkg::S_IDLE : sep_pkg::S_DATA;
            s_nxt.ch[c].rx_cnt = BIT_M1;
            s_nxt.ch[c].rx_bit = 3'h0;
          end
        end
        sep_pkg::S_DATA: begin
          if (s_r.ch[c].rx_cnt == 16'h0) begin
            s_nxt.ch[c].rx_sh  = {rxd[c], s_r.ch[c].rx_sh[7:1]};
            s_nxt.ch[c].rx_cnt = BIT_M1;
            s_nxt.ch[c].rx_bit = s_r.ch[c].rx_bit + 3'h1;
            if (s_r.ch[c].rx_bit == 3'(sep_pkg::DATA_BITS - 1)) begin
              s_nxt.ch[c].rx_st = sep_pkg::S_STOP;
            end
          end
        end
        sep_pkg::S_STOP: begin
          if (s_r.ch[c].rx_cnt == 16'h0) begin
            s_nxt.ch[c].rx_st = sep_pkg::S_IDLE;
            // a good stop bit delivers; a new character wins over a consume
            if (rxd[c]) begin
              s_nxt.ch[c].hold_v = 1'b1;
              s_nxt.ch[c].hold_d = s_r.ch[c].rx_sh;
            end
          end
        end
        default: s_nxt.ch[c].rx_st = sep_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.ch[0].rx_st <= sep_pkg::S_IDLE;
      s_r.ch[1].rx_st <= sep_pkg::S_IDLE;
      s_r.ch[0].tx_st <= sep_pkg::S_IDLE;
      s_r.ch[1].tx_st <= sep_pkg::S_IDLE;
      s_r.ch[0].txd   <= 1'b1;
      s_r.ch[1].txd   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign pc_txd  = s_r.ch[0].txd;
  assign net_txd = s_r.ch[1].txd;
  assign net_de  = s_r.ch[1].de;
  assign dout    = s_r.dout;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_point_set;
    done && pwrite && paddr == sep_pkg::OFS_POINT && pt_ok(pwdata)
    |=> dout == (($past(dout) & ~(80'h1 << pt_idx($past(pwdata))))
                 | (80'($past(pwdata[sep_pkg::VAL_BIT])) << pt_idx($past(pwdata))));
  endproperty
  a_point_set: assert property (p_point_set) else $error("point write wrong");

  property p_point_range;
    done && pwrite && paddr == sep_pkg::OFS_POINT && !pt_ok(pwdata) |=> $stable(dout);
  endproperty
  a_point_range: assert property (p_point_range) else $error("bad point moved");

  property p_point_read;
    psel && !penable && !pwrite && paddr == sep_pkg::OFS_POINT
    ##1 penable [*2] |-> pready && prdata == 32'h0;
  endproperty
  a_point_read: assert property (p_point_read) else $error("point read nonzero");

  property p_lb_mode;
    ##1 s_r.lb == ($past(dip_bank2) == sep_pkg::LB_PATTERN);
  endproperty
  a_lb_mode: assert property (p_lb_mode) else $error("loopback mode wrong");

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ch
      property p_echo;
        s_r.lb && s_r.ch[g].hold_v && s_r.ch[g].tx_st == sep_pkg::S_IDLE
        |=> s_r.ch[g].tx_st == sep_pkg::S_START && s_r.ch[g].tx_sh == $past(s_r.ch[g].hold_d);
      endproperty
      a_echo: assert property (p_echo) else $error("echo missing");

      property p_no_echo;
        !s_r.lb && !txw && s_r.ch[g].tx_st == sep_pkg::S_IDLE |=> s_r.ch[g].tx_st == sep_pkg::S_IDLE;
      endproperty
      a_no_echo: assert property (p_no_echo) else $error("unexpected send");

      property p_duplex;
        s_r.ch[g].rx_st == sep_pkg::S_IDLE && !rxd[g] |=> s_r.ch[g].rx_st == sep_pkg::S_START;
      endproperty
      a_duplex: assert property (p_duplex) else $error("receiver stalled");

      property p_start_low;
        s_r.ch[g].tx_st == sep_pkg::S_START |-> !s_r.ch[g].txd && s_r.ch[g].de;
      endproperty
      a_start_low: assert property (p_start_low) else $error("start bit high");

      property p_stop_high;
        s_r.ch[g].tx_st == sep_pkg::S_STOP |-> s_r.ch[g].txd ##1 s_r.ch[g].txd;
      endproperty
      a_stop_high: assert property (p_stop_high) else $error("stop bit low");

      c_echo: cover property (s_r.lb && s_r.ch[g].hold_v ##1 s_r.ch[g].tx_st == sep_pkg::S_START);
    end
  endgenerate

  c_point_on: cover property (done && pwrite && paddr == sep_pkg::OFS_POINT && pt_ok(pwdata));
  c_full:     cover property (s_r.fcnt == 2'h2);

endmodule

// file: verif/sep_term_model.sv
// serial terminal model for one port: sends frames and collects heard characters
// assumes one clock and a bit time of BIT_CYC cycles on idle-high lines
`timescale 1ns/1ns
module sep_term_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic line_in
);
  logic [7:0] got[$];
  logic [7:0] rx_sh;

  initial line_out = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // send start, eight data bits lsb first, one stop, no parity
  task automatic send(input logic [7:0] c);
    logic [9:0] fr;
    begin
      fr = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
        line_out <= fr[i];
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  endtask

  // listen apart from sending: full duplex, no flow control
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        rx_sh[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (line_in === 1'b1) got.push_back(rx_sh);
    end
  end
endmodule

// file: verif/sep_top_tb.sv
// testbench for the output points and serial echo block
// assumes sep_top with a short bit time and two terminal models
`timescale 1ns/1ns
module sep_top_tb;
  localparam int BIT = 16;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, e, v;
  logic                     pc_rxd, pc_txd, net_rxd, net_txd, net_de;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, q;
  logic [31:0]              rxq[$];
  logic [7:0]               dip_bank2, c;
  logic [7:0]               pat[5] = '{8'h10, 8'h00, 8'h30, 8'h11, 8'hef};
  int                       ptab[6] = '{17, 96, 16, 97, 0, 17};
  logic [sep_pkg::NOUT-1:0] dout, dm;
  int                       errors, samples_checked, cycles, seed, p;

  sep_top #(.BIT_CYC(BIT)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dip_bank2(dip_bank2), .pc_rxd(pc_rxd),
    .pc_txd(pc_txd), .net_rxd(net_rxd), .net_txd(net_txd), .net_de(net_de), .dout(dout));
  sep_term_model #(.BIT_CYC(BIT)) pc_u (.clk(pclk), .line_out(pc_rxd), .line_in(pc_txd));
  sep_term_model #(.BIT_CYC(BIT)) net_u (.clk(pclk), .line_out(net_rxd), .line_in(net_txd));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // compare helpers and closing report
  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk_dout(input logic [sep_pkg::NOUT-1:0] x, input logic [sep_pkg::NOUT-1:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("unexpected dout expected %h seen %h", x, g);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // apb transfer: setup, access held until pready, release, one idle edge
  // only the hang guard ends a wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk_word(n, x, q);
  endtask

  // wait a bounded time for a character heard by a terminal
  task automatic get_char(input int ch, input logic [7:0] x);
    int n;
    begin
      n = 0;
      while ((ch ? net_u.got.size() : pc_u.got.size()) == 0 && n < 12 * BIT) begin
        @(posedge pclk);
        n++;
      end
      c = 8'hxx;
      if (ch != 0 && net_u.got.size() > 0) c = net_u.got.pop_front();
      if (ch == 0 && pc_u.got.size() > 0) c = pc_u.got.pop_front();
      chk_word("char", {24'h0, x}, {24'h0, c});
    end
  endtask

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h1da73d83;
    cycles = 0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    dip_bank2 = 8'h00;
    presetn = 1'b0;
    dm = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_dout(dm, dout);
    chk_word("idle_lines", 32'h3, {29'h0, net_de, pc_txd, net_txd});
    foreach (pat[i]) begin
      dip_bank2 <= pat[i];
      repeat (3) @(posedge pclk);
      rd("status_lb", sep_pkg::OFS_STATUS, {31'h0, pat[i] == 8'h10});
    end
    for (int k = 0; k < 36; k++) begin
      p = (k < 6) ? ptab[k] : 17 + int'($unsigned($random(seed)) % 80);
      v = (k < 6) ? (k != 5) : 1'($random(seed));
      apb(1'b1, sep_pkg::OFS_POINT, {23'h0, v, 1'b0, 7'(p)});
      if (p >= 17 && p <= 96) dm[p - 17] = v;
      chk_dout(dm, dout);
    end
    rd("point_read", sep_pkg::OFS_POINT, 32'h0);
    rd("unmapped", 12'h010, 32'h0);
    chk_word("slverr", 32'h1, {31'h0, e});
    // normal traffic on a near-miss switch setting, both ports at once
    dip_bank2 <= 8'h30;
    c = 8'($random(seed));
    rxq.push_back({24'h800000, c});
    p = $random(seed);
    rxq.push_back({24'h800001, 8'(p)});
    fork
      pc_u.send(c);
      net_u.send(8'(p));
    join
    c = 8'($random(seed));
    rxq.push_back({24'h800000, c});
    p = $random(seed);
    fork
      pc_u.send(c);
      apb(1'b1, sep_pkg::OFS_TXDATA, {24'h0, 8'(p)});
    join
    get_char(0, 8'(p));
    repeat (BIT) @(posedge pclk); // pc transmitter leaves its stop bit first
    rd("status_full", sep_pkg::OFS_STATUS, 32'h12);
    while (rxq.size() > 0) rd("rxdata", sep_pkg::OFS_RXDATA, rxq.pop_front());
    apb(1'b0, sep_pkg::OFS_RXDATA, 32'h0);
    chk_word("rx_empty", 32'h0, {31'h0, q[31]});
    c = 8'($random(seed));
    apb(1'b1, sep_pkg::OFS_TXDATA, {23'h0, 1'b1, c});
    rd("status_busy", sep_pkg::OFS_STATUS, 32'h8);
    // a second send while the net port is busy must not disturb the frame
    apb(1'b1, sep_pkg::OFS_TXDATA, {23'h0, 1'b1, ~c});
    get_char(1, c);
    repeat (BIT) @(posedge pclk);
    chk_word("de_idle", 32'h0, {31'h0, net_de});
    repeat (12 * BIT) @(posedge pclk);
    chk_word("tx_busy_drop", 32'h0, 32'(net_u.got.size()));
    // loopback echo on both ports, software sends ignored meanwhile
    dip_bank2 <= 8'h10;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 2; i++) begin
      c = 8'($random(seed));
      if (i == 1) net_u.send(c);
      else pc_u.send(c);
      get_char(i, c);
    end
    apb(1'b1, sep_pkg::OFS_TXDATA, 32'h5a);
    repeat (12 * BIT) @(posedge pclk);
    chk_word("tx_blocked", 32'h0, 32'(pc_u.got.size()));
    apb(1'b0, sep_pkg::OFS_RXDATA, 32'h0);
    chk_word("lb_no_buffer", 32'h0, {31'h0, q[31]});
    summarize();
  end
endmodule
